//--- break_match_unit.sv
// Two-channel break match unit with a classic Wishbone register slave
//
// Summary of operation
// - Address bits with mask bit one are left out of the compare.
// - A fetch channel set for write never matches.
// - Fetches compare even addresses, so an odd unmasked setting never hits.
// - Data read with size left out matches byte, word and longword.
// - Word write with low byte masked matches the whole masked range.
// - An I-bus fetch setting is ignored and never breaks.
// - I-bus data matches only cycles of the selected master.
// - Control bit per channel, fetch matches only: one breaks after execution, zero before.
// - Break request is high while any match flag is one.
// - Clearing the flags withdraws the request; it holds until then.
// - No enable bit for the break; its level is fixed at 15.
// - Each channel watches the CPU bus or the I bus, never both.
// - A stronger exception on the same instruction keeps the break pending.
// - Pre-execution break on a delay slot waits for the branch target.
// - In standby all breaks are off; registers must not be accessed.
// - Pre break on lower half of a 32-bit instruction acts as post.
// - A pre break after a divide fires even if the divide is suspended.
// - Data compare drops bits 1-0 for longword, bit 0 for word.
//
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module break_match_unit #(
	parameter int CHANNELS = 2
) (
	// Clock and reset
	input  wire logic                              clk_i,
	input  wire logic                              rst_i,
	// Wishbone slave
	input  wire logic                              wb_cyc_i,
	input  wire logic                              wb_stb_i,
	input  wire logic                              wb_we_i,
	input  wire logic [7:0]                        wb_adr_i,
	input  wire logic [3:0]                        wb_sel_i,
	input  wire logic [31:0]                       wb_dat_i,
	output logic      [31:0]                       wb_dat_o,
	output logic                                   wb_ack_o,
	// CPU-side bus
	input  wire logic                              cbus_valid_i,
	input  wire logic [31:0]                       cbus_addr_i,
	input  wire logic                              cbus_fetch_i,
	input  wire logic                              cbus_write_i,
	input  wire logic [1:0]                        cbus_size_i,
	input  wire logic                              cbus_low_half_i,
	// Internal multi-master bus
	input  wire logic                              ibus_valid_i,
	input  wire logic [31:0]                       ibus_addr_i,
	input  wire logic                              ibus_write_i,
	input  wire logic [1:0]                        ibus_size_i,
	input  wire logic [break_unit_pkg::MST_W-1:0]  ibus_master_i,
	// Core execution boundary and power state
	input  wire logic                              exec_bound_i,
	input  wire logic                              exec_slot_i,
	input  wire logic                              exec_exc_i,
	input  wire logic                              standby_i,
	// Break outputs
	output logic                                   break_req_o,
	output logic      [3:0]                        break_level_o,
	output logic                                   break_take_o
);

	// ************************************************
	// Elaboration check
	// ************************************************
	if (CHANNELS != 2) begin : g_bad_channels
		$error("break_match_unit serves exactly two channels");
	end

	// ************************************************
	// Register state
	// ************************************************
	logic [31:0]                       ch_addr [CHANNELS];
	logic [31:0]                       ch_mask [CHANNELS];
	logic [break_unit_pkg::COND_W-1:0] ch_cond [CHANNELS];
	logic [31:0]                       ctrl;
	logic [break_unit_pkg::FLG_CPU_W-1:0] cpu_flags;
	logic [CHANNELS-1:0]               int_flags;

	logic [31:0]                       next_ch_addr [CHANNELS];
	logic [31:0]                       next_ch_mask [CHANNELS];
	logic [break_unit_pkg::COND_W-1:0] next_ch_cond [CHANNELS];
	logic [31:0]                       next_ctrl;
	logic [break_unit_pkg::FLG_CPU_W-1:0] next_cpu_flags;
	logic [CHANNELS-1:0]               next_int_flags;
	logic [31:0]                       next_dat;
	logic                              next_ack;
	logic                              next_req;

	// ************************************************
	// Bus slave helpers
	// ************************************************
	logic        access;
	logic        wr;
	logic [31:0] bmask;

	// One access per request; ack follows one cycle later
	assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr     = access && wb_we_i;
	assign bmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// Merge write data under the byte lanes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
	                                      input logic [31:0] lanes);
		merge = (old & ~lanes) | (dat & lanes);
	endfunction

	// ************************************************
	// Match comparators, two per channel
	// ************************************************
	logic [CHANNELS-1:0] c_hit;
	logic [CHANNELS-1:0] i_hit;
	logic [CHANNELS-1:0] post_sel;

	// Each channel sees both buses, its setting picks one
	for (genvar n = 0; n < CHANNELS; n++) begin : g_chan
		match_channel #(
			.IBUS (1'b0)
		) u_cbus (
			.ch_addr_i (ch_addr[n]),
			.ch_mask_i (ch_mask[n]),
			.ch_cond_i (ch_cond[n]),
			.valid_i   (cbus_valid_i && !standby_i),
			.addr_i    (cbus_addr_i),
			.fetch_i   (cbus_fetch_i),
			.write_i   (cbus_write_i),
			.size_i    (cbus_size_i),
			.master_i  ('0),
			.hit_o     (c_hit[n])
		);
		match_channel #(
			.IBUS (1'b1)
		) u_ibus (
			.ch_addr_i (ch_addr[n]),
			.ch_mask_i (ch_mask[n]),
			.ch_cond_i (ch_cond[n]),
			.valid_i   (ibus_valid_i && !standby_i),
			.addr_i    (ibus_addr_i),
			.fetch_i   (1'b0),
			.write_i   (ibus_write_i),
			.size_i    (ibus_size_i),
			.master_i  (ibus_master_i),
			.hit_o     (i_hit[n])
		);
		// Post timing from control bit or a lower half
		assign post_sel[n] = cbus_fetch_i &&
		                     (ctrl[break_unit_pkg::CTRL_POST_LSB + n] || cbus_low_half_i);
	end

	// ************************************************
	// Break acceptance
	// ************************************************
	logic pre_hit;
	logic post_hit;

	// Data and pre fetch matches wait for a boundary
	assign pre_hit  = |(c_hit & ~post_sel) || |i_hit;
	assign post_hit = |(c_hit & post_sel);

	break_accept u_accept (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.pre_hit_i  (pre_hit),
		.post_hit_i (post_hit),
		.standby_i  (standby_i),
		.bound_i    (exec_bound_i),
		.slot_i     (exec_slot_i),
		.exc_i      (exec_exc_i),
		.take_o     (break_take_o)
	);

	// ************************************************
	// Register writes and flag updates
	// ************************************************
	// A write lands with ack, so a later read-back sees it
	always_comb begin
		for (int n = 0; n < CHANNELS; n++) begin
			next_ch_addr[n] = ch_addr[n];
			next_ch_mask[n] = ch_mask[n];
			next_ch_cond[n] = ch_cond[n];
		end
		next_ctrl      = ctrl;
		next_cpu_flags = cpu_flags;
		next_int_flags = int_flags;
		if (wr) begin
			case (wb_adr_i)
				break_unit_pkg::OFS_ADDR0: next_ch_addr[0] = merge(ch_addr[0], wb_dat_i, bmask);
				break_unit_pkg::OFS_MASK0: next_ch_mask[0] = merge(ch_mask[0], wb_dat_i, bmask);
				break_unit_pkg::OFS_COND0:
					next_ch_cond[0] = 16'(merge({16'h0, ch_cond[0]}, wb_dat_i, bmask));
				break_unit_pkg::OFS_ADDR1: next_ch_addr[1] = merge(ch_addr[1], wb_dat_i, bmask);
				break_unit_pkg::OFS_MASK1: next_ch_mask[1] = merge(ch_mask[1], wb_dat_i, bmask);
				break_unit_pkg::OFS_COND1:
					next_ch_cond[1] = 16'(merge({16'h0, ch_cond[1]}, wb_dat_i, bmask));
				break_unit_pkg::OFS_CTRL:
					next_ctrl = merge(ctrl, wb_dat_i, bmask) & {{(32-CHANNELS){1'b0}},
					            {CHANNELS{1'b1}}};
				break_unit_pkg::OFS_FLAGS: begin
					// Writing zero clears a flag, writing one keeps it
					if (wb_sel_i[0])
						next_cpu_flags = cpu_flags &
						                 wb_dat_i[break_unit_pkg::FLG_CPU_LSB +: 8];
					if (wb_sel_i[1])
						next_int_flags = int_flags &
						                 wb_dat_i[break_unit_pkg::FLG_INT_LSB +: CHANNELS];
				end
				default: ;
			endcase
		end
		// Set wins over a clear in the same cycle
		next_cpu_flags[CHANNELS-1:0] = next_cpu_flags[CHANNELS-1:0] | c_hit;
		next_int_flags               = next_int_flags | i_hit;
	end

	// ************************************************
	// Read data, ack and request
	// ************************************************
	// Unmapped offsets answer with ack and zero data
	always_comb begin
		next_dat = 32'h0;
		if (access && !wb_we_i) begin
			case (wb_adr_i)
				break_unit_pkg::OFS_ADDR0: next_dat = ch_addr[0];
				break_unit_pkg::OFS_MASK0: next_dat = ch_mask[0];
				break_unit_pkg::OFS_COND0: next_dat = {16'h0, ch_cond[0]};
				break_unit_pkg::OFS_ADDR1: next_dat = ch_addr[1];
				break_unit_pkg::OFS_MASK1: next_dat = ch_mask[1];
				break_unit_pkg::OFS_COND1: next_dat = {16'h0, ch_cond[1]};
				break_unit_pkg::OFS_CTRL:  next_dat = ctrl;
				break_unit_pkg::OFS_FLAGS: begin
					next_dat[break_unit_pkg::FLG_CPU_LSB +: 8]        = cpu_flags;
					next_dat[break_unit_pkg::FLG_INT_LSB +: CHANNELS] = int_flags;
				end
				default: next_dat = 32'h0;
			endcase
		end
		next_ack = access;
		// Request follows any flag, no enable gates it
		next_req = |next_cpu_flags || |next_int_flags;
	end

	// All state registered; level is a constant flop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int n = 0; n < CHANNELS; n++) begin
				ch_addr[n] <= break_unit_pkg::REG_RST;
				ch_mask[n] <= break_unit_pkg::REG_RST;
				ch_cond[n] <= break_unit_pkg::REG_RST[15:0];
			end
			ctrl          <= break_unit_pkg::REG_RST;
			cpu_flags     <= break_unit_pkg::REG_RST[7:0];
			int_flags     <= '0;
			wb_dat_o      <= break_unit_pkg::REG_RST;
			wb_ack_o      <= 1'b0;
			break_req_o   <= 1'b0;
			break_level_o <= break_unit_pkg::BREAK_LEVEL;
		end else begin
			for (int n = 0; n < CHANNELS; n++) begin
				ch_addr[n] <= next_ch_addr[n];
				ch_mask[n] <= next_ch_mask[n];
				ch_cond[n] <= next_ch_cond[n];
			end
			ctrl          <= next_ctrl;
			cpu_flags     <= next_cpu_flags;
			int_flags     <= next_int_flags;
			wb_dat_o      <= next_dat;
			wb_ack_o      <= next_ack;
			break_req_o   <= next_req;
			break_level_o <= break_unit_pkg::BREAK_LEVEL;
		end
	end

endmodule

//--- break_unit_pkg.sv
// Shared constants for the two-channel break match unit
package break_unit_pkg;

	// ************************************************
	// Register offsets (byte addresses)
	// ************************************************
	localparam logic [7:0] OFS_ADDR0 = 8'h00;
	localparam logic [7:0] OFS_MASK0 = 8'h04;
	localparam logic [7:0] OFS_COND0 = 8'h08;
	localparam logic [7:0] OFS_ADDR1 = 8'h0C;
	localparam logic [7:0] OFS_MASK1 = 8'h10;
	localparam logic [7:0] OFS_COND1 = 8'h14;
	localparam logic [7:0] OFS_CTRL  = 8'h18;
	localparam logic [7:0] OFS_FLAGS = 8'h1C;

	// ************************************************
	// Cycle condition fields
	// ************************************************
	localparam int COND_W        = 16;
	localparam int COND_SIZE_LSB = 0;
	localparam int COND_DIR_LSB  = 2;
	localparam int COND_KIND_LSB = 4;
	localparam int COND_BUS_LSB  = 6;
	localparam int COND_MST_LSB  = 8;
	localparam int MST_W         = 4;

	localparam logic [1:0] BUS_C      = 2'h1;
	localparam logic [1:0] BUS_I      = 2'h2;
	localparam logic [1:0] KIND_FETCH = 2'h1;
	localparam logic [1:0] KIND_DATA  = 2'h2;
	localparam logic [1:0] DIR_READ   = 2'h1;
	localparam logic [1:0] DIR_WRITE  = 2'h2;
	localparam logic [1:0] DIR_ANY    = 2'h3;
	localparam logic [1:0] SIZE_ANY   = 2'h0;
	localparam logic [1:0] SIZE_BYTE  = 2'h1;
	localparam logic [1:0] SIZE_WORD  = 2'h2;
	localparam logic [1:0] SIZE_LONG  = 2'h3;

	// ************************************************
	// Control and flag fields, reset values
	// ************************************************
	localparam int CTRL_POST_LSB = 0;
	localparam int FLG_CPU_LSB   = 0;
	localparam int FLG_CPU_W     = 8;
	localparam int FLG_INT_LSB   = 8;
	localparam logic [31:0] REG_RST    = 32'h0000_0000;
	localparam logic [3:0]  BREAK_LEVEL = 4'hF;

	// Break acceptance states, Gray along idle-armed-pending
	typedef enum logic [1:0] {
		ACC_IDLE  = 2'b00,
		ACC_ARMED = 2'b01,
		ACC_PEND  = 2'b11
	} acc_state_e;

endpackage

//--- match_channel.sv
// One channel's compare of one bus cycle
`timescale 1ns/1ps
module match_channel #(
	parameter bit IBUS = 1'b0
) (
	// Channel setting
	input  wire logic [31:0]                        ch_addr_i,
	input  wire logic [31:0]                        ch_mask_i,
	input  wire logic [break_unit_pkg::COND_W-1:0]  ch_cond_i,
	// Bus cycle
	input  wire logic                               valid_i,
	input  wire logic [31:0]                        addr_i,
	input  wire logic                               fetch_i,
	input  wire logic                               write_i,
	input  wire logic [1:0]                         size_i,
	input  wire logic [break_unit_pkg::MST_W-1:0]   master_i,
	// Result
	output logic                                    hit_o
);
	logic [1:0]  bus;
	logic [1:0]  kind;
	logic [1:0]  dir;
	logic [1:0]  size;
	logic [31:0] care;
	logic        ok_kind;
	logic        ok_dir;
	logic        ok_size;
	logic        ok_mst;

	// Field extraction
	assign bus  = ch_cond_i[break_unit_pkg::COND_BUS_LSB +: 2];
	assign kind = ch_cond_i[break_unit_pkg::COND_KIND_LSB +: 2];
	assign dir  = ch_cond_i[break_unit_pkg::COND_DIR_LSB +: 2];
	assign size = ch_cond_i[break_unit_pkg::COND_SIZE_LSB +: 2];

	// Compared bits: mask and data size remove bits
	always_comb begin
		care = ~ch_mask_i;
		if (!fetch_i && size_i == break_unit_pkg::SIZE_LONG)
			care[1:0] = 2'h0;
		else if (!fetch_i && size_i == break_unit_pkg::SIZE_WORD)
			care[0] = 1'b0;
		// Fetches keep bit 0 compared, so an odd setting never hits
	end

	// Qualifiers; I side never serves a fetch
	always_comb begin
		ok_kind = IBUS ? (kind == break_unit_pkg::KIND_DATA && !fetch_i)
		               : ((kind == break_unit_pkg::KIND_FETCH && fetch_i) ||
		                  (kind == break_unit_pkg::KIND_DATA && !fetch_i));
		ok_dir  = (dir == break_unit_pkg::DIR_ANY) ||
		          (dir == break_unit_pkg::DIR_READ && !write_i) ||
		          (dir == break_unit_pkg::DIR_WRITE && write_i);
		ok_size = (size == break_unit_pkg::SIZE_ANY) || (size == size_i);
		ok_mst  = !IBUS ||
		          master_i == ch_cond_i[break_unit_pkg::COND_MST_LSB +: break_unit_pkg::MST_W];
	end

	// Full match on the bus this channel watches
	assign hit_o = valid_i && bus == (IBUS ? break_unit_pkg::BUS_I : break_unit_pkg::BUS_C) &&
	               ok_kind && ok_dir && ok_size && ok_mst && ((addr_i ^ ch_addr_i) & care) == 32'h0;

endmodule

//--- break_accept.sv
// Picks the boundary at which a pending break is taken
`timescale 1ns/1ps
module break_accept (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Match events
	input  wire logic pre_hit_i,
	input  wire logic post_hit_i,
	input  wire logic standby_i,
	// Core boundary information
	input  wire logic bound_i,
	input  wire logic slot_i,
	input  wire logic exc_i,
	// Break taken
	output logic      take_o
);
	break_unit_pkg::acc_state_e state;
	break_unit_pkg::acc_state_e next_state;
	logic                       next_take;

	// Next state; only standby cancels a pending break, so a suspended
	// divide does not stop a break set on the next instruction
	always_comb begin
		next_state = state;
		next_take  = 1'b0;
		case (state)
			break_unit_pkg::ACC_IDLE: begin
				if (pre_hit_i)
					next_state = break_unit_pkg::ACC_PEND;
				else if (post_hit_i)
					next_state = break_unit_pkg::ACC_ARMED;
			end
			break_unit_pkg::ACC_ARMED: begin
				// Matched instruction executes first
				if (bound_i)
					next_state = break_unit_pkg::ACC_PEND;
			end
			break_unit_pkg::ACC_PEND: begin
				// Held past a delay slot and a stronger exception
				if (bound_i && !slot_i && !exc_i) begin
					next_state = break_unit_pkg::ACC_IDLE;
					next_take  = 1'b1;
				end
			end
			default: next_state = break_unit_pkg::ACC_IDLE;
		endcase
		if (standby_i) begin
			next_state = break_unit_pkg::ACC_IDLE;
			next_take  = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state  <= break_unit_pkg::ACC_IDLE;
			take_o <= 1'b0;
		end else begin
			state  <= next_state;
			take_o <= next_take;
		end
	end

endmodule

//--- break_match_unit_monitor.sv
// Concurrent port checks for the break match unit
`timescale 1ns/1ps
module break_match_unit_monitor #(
	parameter int CHANNELS = 2
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [31:0] wb_dat_o,
	input  wire logic        wb_ack_o,
	// Buses, core and power
	input  wire logic        cbus_valid_i,
	input  wire logic        ibus_valid_i,
	input  wire logic        exec_bound_i,
	input  wire logic        exec_slot_i,
	input  wire logic        exec_exc_i,
	input  wire logic        standby_i,
	// Break outputs
	input  wire logic        break_req_o,
	input  wire logic [3:0]  break_level_o,
	input  wire logic        break_take_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ****************************************
	// Named steps
	// ****************************************
	sequence s_wb_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// Two standby samples leave no cycle that could set a flag
	sequence s_quiet_standby;
		standby_i && $past(standby_i) && !break_req_o;
	endsequence

	// ****************************************
	// Assertions
	// ****************************************
	a_ack_next: assert property (s_wb_req |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_rdata_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside ack");
	a_level_fixed: assert property (break_level_o == 4'hF)
		else $error("break level not fifteen");
	a_req_cause: assert property (
		$rose(break_req_o) |-> $past(cbus_valid_i) || $past(ibus_valid_i))
		else $error("break request rose without a bus cycle");
	a_req_hold: assert property (
		$fell(break_req_o) |-> $past(rst_i) || $past(wb_cyc_i && wb_stb_i && wb_we_i))
		else $error("break request dropped without a flag write");
	a_standby_quiet: assert property (s_quiet_standby |=> !break_req_o)
		else $error("break request raised during standby");
	a_take_bound: assert property (
		break_take_o |-> $past(exec_bound_i && !exec_slot_i && !exec_exc_i))
		else $error("break taken off a clean boundary");
endmodule

bind break_match_unit break_match_unit_monitor #(.CHANNELS(CHANNELS)) u_mon (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.cbus_valid_i(cbus_valid_i), .ibus_valid_i(ibus_valid_i),
	.exec_bound_i(exec_bound_i), .exec_slot_i(exec_slot_i), .exec_exc_i(exec_exc_i),
	.standby_i(standby_i), .break_req_o(break_req_o), .break_level_o(break_level_o),
	.break_take_o(break_take_o));

//--- core_bus_model.sv
// Core and internal bus masters feeding the break unit
`timescale 1ns/1ps
module core_bus_model (
	// Clock
	input  wire logic                             clk_i,
	// CPU-side bus
	output logic                                  cbus_valid_o,
	output logic [31:0]                           cbus_addr_o,
	output logic                                  cbus_fetch_o,
	output logic                                  cbus_write_o,
	output logic [1:0]                            cbus_size_o,
	output logic                                  cbus_low_half_o,
	// Internal bus
	output logic                                  ibus_valid_o,
	output logic [31:0]                           ibus_addr_o,
	output logic                                  ibus_write_o,
	output logic [1:0]                            ibus_size_o,
	output logic [break_unit_pkg::MST_W-1:0]      ibus_master_o,
	// Execution boundary
	output logic                                  bound_o,
	output logic                                  slot_o,
	output logic                                  exc_o
);
	// Idle buses
	initial begin
		{cbus_valid_o, cbus_fetch_o, cbus_write_o, cbus_low_half_o} = 4'h0;
		{ibus_valid_o, ibus_write_o, bound_o, slot_o, exc_o} = 5'h0;
		{cbus_addr_o, ibus_addr_o} = 64'h0;
		{cbus_size_o, ibus_size_o, ibus_master_o} = 8'h0;
	end

	// One bus cycle; a released address shows its inverse
	task automatic cycle(input bit ib, input logic [31:0] a, input bit f, w,
			input logic [1:0] sz, input logic [3:0] m, input bit lh);
		@(posedge clk_i);
		if (ib) begin
			{ibus_valid_o, ibus_write_o, ibus_size_o, ibus_master_o} <= {1'b1, w, sz, m};
			ibus_addr_o <= a;
		end else begin
			{cbus_valid_o, cbus_fetch_o, cbus_write_o} <= {1'b1, f, w};
			{cbus_size_o, cbus_low_half_o} <= {sz, lh};
			cbus_addr_o <= a;
		end
		@(posedge clk_i);
		{cbus_valid_o, ibus_valid_o} <= 2'h0;
		{cbus_addr_o, ibus_addr_o} <= {~a, ~a};
	endtask

	// One instruction boundary
	task automatic mark(input bit sl, ex);
		@(posedge clk_i);
		{bound_o, slot_o, exc_o} <= {1'b1, sl, ex};
		@(posedge clk_i);
		{bound_o, slot_o, exc_o} <= 3'h0;
	endtask
endmodule

//--- break_match_unit_tb.sv
// Self-checking bench for the two-channel break match unit
`timescale 1ns/1ps
module break_match_unit_tb;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, standby_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i, ibus_master, break_level_o;
	logic [31:0] wb_dat_i, wb_dat_o, cbus_addr, ibus_addr;
	logic        cbus_valid, cbus_fetch, cbus_write, cbus_low_half, ibus_valid, ibus_write;
	logic [1:0]  cbus_size, ibus_size;
	logic        bound, slot, exc, break_req_o, break_take_o;
	int          n_mismatch, checks_done, cycles;
	// Example settings: address, mask, condition
	logic [31:0] ta [8] = '{32'h404, 32'h8010, 32'h27128, 32'h31415, 32'h123456,
		32'hABCDE, 32'h314156, 32'h55555};
	logic [31:0] tm [8] = '{32'h0, 32'h6, 32'h0, 32'h0, 32'h0, 32'hFF, 32'h0, 32'h0};
	logic [15:0] tc [8] = '{16'h0054, 16'h0054, 16'h005A, 16'h0054, 16'h0064,
		16'h006A, 16'h0094, 16'h02A9};

	break_match_unit #(.CHANNELS(2)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.cbus_valid_i(cbus_valid), .cbus_addr_i(cbus_addr), .cbus_fetch_i(cbus_fetch),
		.cbus_write_i(cbus_write), .cbus_size_i(cbus_size), .cbus_low_half_i(cbus_low_half),
		.ibus_valid_i(ibus_valid), .ibus_addr_i(ibus_addr), .ibus_write_i(ibus_write),
		.ibus_size_i(ibus_size), .ibus_master_i(ibus_master), .exec_bound_i(bound),
		.exec_slot_i(slot), .exec_exc_i(exc), .standby_i(standby_i),
		.break_req_o(break_req_o), .break_level_o(break_level_o), .break_take_o(break_take_o));

	core_bus_model u_core (.clk_i(clk_i), .cbus_valid_o(cbus_valid), .cbus_addr_o(cbus_addr),
		.cbus_fetch_o(cbus_fetch), .cbus_write_o(cbus_write), .cbus_size_o(cbus_size),
		.cbus_low_half_o(cbus_low_half), .ibus_valid_o(ibus_valid), .ibus_addr_o(ibus_addr),
		.ibus_write_o(ibus_write), .ibus_size_o(ibus_size), .ibus_master_o(ibus_master),
		.bound_o(bound), .slot_o(slot), .exc_o(exc));

	// ****************************************
	// Clock, timeout and shared tasks
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	// Ceiling far above the test length
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 30000) begin
			n_mismatch++;
			close_out();
		end
	end

	task automatic close_out();
		if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Classic cycle, held until ack is sampled high
	task automatic wb(input bit we, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s, output logic [31:0] q);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, a, s, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
	endtask

	// Expected hit of one channel
	function automatic bit ehit(input logic [31:0] a, m, input logic [15:0] c, input bit ib, f,
			w, input logic [1:0] sz, input logic [3:0] ms, input logic [31:0] x);
		logic [31:0] ign;
		bit ok;
		ign = m | (f ? 32'h0 : sz == 2'h3 ? 32'h3 : sz == 2'h2 ? 32'h1 : 32'h0);
		ok = ((a ^ x) & ~ign) == 32'h0 && (w ? c[3] : c[2]) && (c[1:0] == 2'h0 || c[1:0] == sz);
		if (ib) ok = ok && c[7:4] == 4'hA && c[11:8] == ms;
		else ok = ok && c[7:6] == 2'h1 && c[5:4] == (f ? 2'h1 : 2'h2);
		return ok;
	endfunction

	// Standby flush, one fetch hit, two boundaries
	task automatic acc(input bit post, lh, sl, ex, fst);
		logic [31:0] q;
		wb(1'b1, 8'h18, {31'h0, post}, 4'hF, q); // Channel 0 post bit from post, then a standby pulse
		@(posedge clk_i) standby_i <= 1'b1;
		@(posedge clk_i) standby_i <= 1'b0;
		u_core.cycle(1'b0, 32'h404, 1'b1, 1'b0, 2'h2, 4'h0, lh);
		u_core.mark(sl, ex);
		#1 check({31'h0, break_take_o}, {31'h0, fst});
		u_core.mark(1'b0, 1'b0);
		#1 check({31'h0, break_take_o}, {31'h0, !fst});
		wb(1'b1, 8'h1C, 32'h0, 4'h3, q);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [31:0] q, x, e;
		logic [31:0] ca [2], cm [2];
		logic [15:0] cc [2];
		bit ib, f, w;
		logic [1:0] sz;
		logic [3:0] ms;
		int p;
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, standby_i} = 5'h10;
		{wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
		q = $urandom(34749);
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		#1 check({28'h0, break_level_o}, 32'hF);
		// Reset values, then an unmapped offset
		for (p = 0; p <= 32; p += 4) begin
			wb(1'b0, p[7:0], 32'h0, 4'hF, q);
			check(q, 32'h0);
		end
		wb(1'b1, 8'h20, 32'hFFFFFFFF, 4'hF, q);
		wb(1'b0, 8'h20, 32'h0, 4'hF, q);
		check(q, 32'h0);
		// Random cycles against random pairs of settings
		repeat (60) begin
			for (int k = 0; k < 2; k++) begin
				p = $urandom % 8;
				{ca[k], cm[k], cc[k]} = {ta[p], tm[p], tc[p]};
				wb(1'b1, 8'(12 * k), ca[k], 4'hF, q);
				wb(1'b1, 8'(12 * k + 4), cm[k], 4'hF, q);
				wb(1'b1, 8'(12 * k + 8), {16'h0, cc[k]}, 4'hF, q);
			end
			wb(1'b0, 8'h14, 32'h0, 4'hF, q); // Read back before relying on it
			check(q, {16'h0, cc[1]});
			ib = $urandom % 2;
			f = !ib && ($urandom % 2);
			w = !f && ($urandom % 2);
			sz = f ? 2'h2 : 2'($urandom % 3 + 1);
			ms = 4'($urandom % 4);
			x = ca[$urandom % 2];
			p = $urandom % 4;
			x = p == 0 ? x : p == 1 ? x ^ ($urandom & 3) : p == 2 ? x ^ ($urandom & 255) : $urandom;
			if (f) x[0] = 1'b0;
			u_core.cycle(ib, x, f, w, sz, ms, 1'b0);
			e = {30'h0, ehit(ca[1], cm[1], cc[1], ib, f, w, sz, ms, x),
				ehit(ca[0], cm[0], cc[0], ib, f, w, sz, ms, x)} << (ib ? 8 : 0);
			repeat (2) @(posedge clk_i);
			#1 check({31'h0, break_req_o}, {31'h0, e != 0});
			wb(1'b0, 8'h1C, 32'h0, 4'hF, q);
			check(q, e);
			wb(1'b1, 8'h1C, 32'h0, 4'h3, q);
			@(posedge clk_i);
			#1 check({31'h0, break_req_o}, 32'h0);
		end
		// Standby ignores a matching fetch
		wb(1'b1, 8'h00, 32'h404, 4'hF, q);
		wb(1'b1, 8'h04, 32'h0, 4'hF, q);
		wb(1'b1, 8'h08, 32'h0054, 4'hF, q);
		wb(1'b1, 8'h14, 32'h0, 4'hF, q);
		@(posedge clk_i) standby_i <= 1'b1;
		u_core.cycle(1'b0, 32'h404, 1'b1, 1'b0, 2'h2, 4'h0, 1'b0);
		@(posedge clk_i) standby_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1 check({31'h0, break_req_o}, 32'h0);
		wb(1'b0, 8'h1C, 32'h0, 4'hF, q);
		check(q, 32'h0);
		// Pre, post, lower half, delay slot, stronger exception
		acc(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
		acc(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		acc(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		acc(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		acc(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
		close_out();
	end
endmodule
